// >>> rtl/bridge_pm_pkg.sv
// Constants, types and register map of the bridge power-management block
//Contract
//- In D0 the wake status flag sets on any unmasked event.
//- With skip set, unmasked means flag and mask bit both set.
//- With skip clear, unmasked also needs the global interrupt enable.
//- Identification register bit 26 reads the skip bit.
//- Wake output is open-drain: pull low or release.
//- With wake enabled, card insertion asserts the wake output.
//- Refuse clock stop while either hold-clock bit is set.
//- Refuse clock stop while card side is busy, posted or clocked.
//- Refuse clock stop while serial bus side is busy, pending or active.
//- Request clock restart on card interrupt or status, wake, ring event.
//- Request restart on card clock-run start or card bus request.
//- Request restart when the serial bus goes idle to active.
//- Request restart on hold, FIFO data, busy master or pending interrupt.
//- Stop the card clock when the card is idle, via card clock-run.
//- Card output enable bit floats the card interface and resets the card.
//- Auto power down floats the idle card without a reset.
//- Suspend blocks both reset inputs and gates the PCI clock.
//- A reset while suspended keeps register contents.
//- Suspend floats PCI outputs and gates clock, deferred while granted.
//- Ring and multifunction outputs keep working during suspend.
//- Serial-stream status interrupts wait for the PCI clock.
//- Power state field encodes only D0, D1, D2 and D3hot.
package bridge_pm_pkg;
	localparam int          ADDR_W     = 8;
	localparam int          EV_W       = 16;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_MASK   = 8'h04;
	localparam logic [7:0]  OFF_FLAGS  = 8'h08;
	localparam logic [7:0]  OFF_PMCSR  = 8'h0c;
	localparam logic [7:0]  OFF_STATUS = 8'h10;
	localparam logic [7:0]  OFF_IDENT  = 8'h14;
	localparam int          B_HOLD     = 0;
	localparam int          B_HOLD_ALT = 1;
	localparam int          B_SKIP     = 2;
	localparam int          B_GIE      = 3;
	localparam int          B_COE      = 4;
	localparam int          B_APD      = 5;
	localparam int          B_RING_EN  = 6;
	localparam int          PM_WAKE_EN = 8;
	localparam int          PM_WAKE_ST = 15;
	localparam int          ID_SKIP    = 26;
	localparam logic [6:0]  CTRL_RST   = 7'h00;
	localparam logic [15:0] MASK_RST   = 16'h0000;
	// Arbitrary identity value
	localparam logic [31:0] IDENT_BASE = 32'h0000_5a5a;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	localparam int          CLK_NS     = 25;
	localparam int          CRUN_NS    = 50;
	localparam int          CRUN_CYC   = (CRUN_NS + CLK_NS - 1) / CLK_NS;
	localparam int          IDLE_NS    = 1000;
	localparam int          IDLE_CYC   = (IDLE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {PS_D0 = 2'h0, PS_D1 = 2'h1, PS_D2 = 2'h2, PS_D3HOT = 2'h3} pstate_t;
	typedef enum logic [2:0] {CR_IDLE = 3'h1, CR_DRIVE = 3'h2, CR_REL = 3'h4} crun_t;
	typedef enum logic [2:0] {CC_RUN = 3'h1, CC_REQ = 3'h2, CC_STOP = 3'h4} cclk_t;
	typedef struct packed {
		logic card_rm_busy;
		logic card_master_busy;
		logic card_posted;
		logic sbus_rm_busy;
		logic sbus_master_busy;
		logic sbus_posted;
		logic sbus_not_idle;
		logic fifo_data;
	} busy_t;
	typedef struct packed {
		logic card_irq;
		logic card_stschg;
		logic card_req;
		logic sbus_active;
	} wake_src_t;
endpackage

// >>> rtl/bridge_power_management.sv
// Power management: wake events, PCI clock-run, card clock, suspend gating
`timescale 1ns/10ps
module bridge_power_management (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [bridge_pm_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [31:0]                       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [bridge_pm_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [31:0]                            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic [bridge_pm_pkg::EV_W-1:0]    event_in,
	input  wire logic                              card_insert,
	input  wire bridge_pm_pkg::busy_t              busy,
	input  wire bridge_pm_pkg::wake_src_t          wake_src,
	input  wire logic                              card_idle,
	input  wire logic                              ring_in,
	input  wire logic                              suspend_in,
	input  wire logic                              pci_reset_input_n,
	input  wire logic                              global_reset_input_n,
	input  wire logic                              gnt_active,
	input  wire logic                              clkrun_i,
	output logic                                   clkrun_o,
	output logic                                   clkrun_oe,
	input  wire logic                              cclkrun_i,
	output logic                                   cclkrun_o,
	output logic                                   cclkrun_oe,
	output logic                                   wake_o,
	output logic                                   wake_oe,
	output logic                                   ring_wake_output,
	output logic                                   card_clk_en,
	output logic                                   card_hiz,
	output logic                                   card_reset,
	output logic                                   pci_out_hiz,
	output logic                                   pci_clk_gate,
	output logic                                   pci_reset_out_n,
	output logic                                   global_reset_out_n,
	input  wire logic                              csc_serial_req,
	output logic                                   csc_serial_send
);
	import bridge_pm_pkg::*;

	logic [6:0]      ctrl_q;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] flags_q;
	pstate_t         pstate_q;
	logic            wake_en_q;
	logic            wake_st_q;
	logic            susp_q;
	logic            sbus_act_q;
	logic [7:0]      waddr_q;
	logic [31:0]     wdata_q;
	logic [3:0]      wstrb_q;
	crun_t           cr_q;
	cclk_t           cc_q;
	logic [7:0]      cr_cnt_q;
	logic [7:0]      idle_cnt_q;

	// Suspended resets are blocked, so configuration survives them
	wire reg_rst     = ~aresetn |
		(~susp_q & ~(pci_reset_input_n & global_reset_input_n));
	wire aw_fire     = s_axi_awvalid & s_axi_awready;
	wire w_fire      = s_axi_wvalid & s_axi_wready;
	wire b_fire      = s_axi_bvalid & s_axi_bready;
	wire ar_fire     = s_axi_arvalid & s_axi_arready;
	wire r_fire      = s_axi_rvalid & s_axi_rready;
	wire wr_go       = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire [31:0] wmsk = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire wr_ctrl     = wr_go & (waddr_q == OFF_CTRL);
	wire wr_mask     = wr_go & (waddr_q == OFF_MASK);
	wire wr_flags    = wr_go & (waddr_q == OFF_FLAGS);
	wire wr_pmcsr    = wr_go & (waddr_q == OFF_PMCSR);
	wire wr_hit      = wr_ctrl | wr_mask | wr_flags | wr_pmcsr;
	wire [31:0] wnew = wdata_q & wmsk;

	// Per-bit qualification, then one OR
	wire [EV_W-1:0] unmasked = flags_q & mask_q &
		{EV_W{ctrl_q[B_SKIP] | ctrl_q[B_GIE]}};
	wire irq_pend    = |unmasked;
	wire wake_set    = ((pstate_q == PS_D0) & irq_pend) |
		(card_insert & wake_en_q);
	wire wake_clr    = wr_pmcsr & wnew[PM_WAKE_ST];
	wire hold_any    = ctrl_q[B_HOLD] | ctrl_q[B_HOLD_ALT];
	wire refuse_stop = hold_any |
		busy.card_rm_busy | busy.card_master_busy | busy.card_posted |
		(cc_q != CC_STOP) |
		busy.sbus_rm_busy | busy.sbus_master_busy | busy.sbus_posted |
		irq_pend | busy.sbus_not_idle;
	wire cc_wake     = (cc_q == CC_STOP) & ~cclkrun_i;
	wire restart     = wake_src.card_irq | wake_src.card_stschg | ring_in |
		cc_wake | wake_src.card_req |
		(wake_src.sbus_active & ~sbus_act_q) |
		ctrl_q[B_HOLD] | busy.fifo_data | busy.sbus_master_busy |
		irq_pend;
	wire need_clk    = refuse_stop | restart;

	wire [31:0] rd_ctrl   = {25'h0, ctrl_q};
	wire [31:0] rd_pmcsr  = {16'h0, wake_st_q, 6'h0, wake_en_q, 6'h0, pstate_q};
	wire [31:0] rd_status = {24'h0, cc_q, cr_q, susp_q, refuse_stop};
	wire [31:0] rd_ident  = IDENT_BASE | ({31'h0, ctrl_q[B_SKIP]} << ID_SKIP);
	wire        rd_hit    = (s_axi_araddr == OFF_CTRL) | (s_axi_araddr == OFF_MASK) |
		(s_axi_araddr == OFF_FLAGS) | (s_axi_araddr == OFF_PMCSR) |
		(s_axi_araddr == OFF_STATUS) | (s_axi_araddr == OFF_IDENT);
	wire [31:0] rd_val    =
		(s_axi_araddr == OFF_CTRL)   ? rd_ctrl :
		(s_axi_araddr == OFF_MASK)   ? {16'h0, mask_q} :
		(s_axi_araddr == OFF_FLAGS)  ? {16'h0, flags_q} :
		(s_axi_araddr == OFF_PMCSR)  ? rd_pmcsr :
		(s_axi_araddr == OFF_STATUS) ? rd_status :
		(s_axi_araddr == OFF_IDENT)  ? rd_ident : 32'h0;

	// Bus slave: address and data in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
			waddr_q       <= 8'h0;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
		end else begin
			if (aw_fire) begin
				s_axi_awready <= 1'b0;
				waddr_q       <= s_axi_awaddr;
			end
			if (w_fire) begin
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLV;
			end
			if (b_fire) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (ar_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLV;
			end
			if (r_fire) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Configuration and status registers
	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			ctrl_q    <= CTRL_RST;
			mask_q    <= MASK_RST;
			flags_q   <= '0;
			pstate_q  <= PS_D0;
			wake_en_q <= 1'b0;
			wake_st_q <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= (ctrl_q & ~wmsk[6:0]) | wnew[6:0];
			if (wr_mask)
				mask_q <= (mask_q & ~wmsk[15:0]) | wnew[15:0];
			// New events win over a simultaneous clear
			flags_q <= (flags_q & ~(wr_flags ? wnew[15:0] : 16'h0)) | event_in;
			if (wr_pmcsr && wmsk[0]) begin
				pstate_q <= pstate_t'(wnew[1:0]);
			end
			if (wr_pmcsr && wmsk[8])
				wake_en_q <= wnew[PM_WAKE_EN];
			wake_st_q <= wake_set | (wake_st_q & ~wake_clr);
		end
	end

	// PCI clock-run: hold the line low to refuse a stop or restart the clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cr_q       <= CR_IDLE;
			cr_cnt_q   <= 8'h0;
			clkrun_o   <= 1'b0;
			clkrun_oe  <= 1'b0;
			sbus_act_q <= 1'b0;
		end else begin
			sbus_act_q <= wake_src.sbus_active;
			case (cr_q)
				CR_IDLE: begin
					if (clkrun_i && need_clk) begin
						cr_q      <= CR_DRIVE;
						cr_cnt_q  <= 8'(CRUN_CYC - 1);
						clkrun_o  <= 1'b0;
						clkrun_oe <= 1'b1;
					end
				end
				CR_DRIVE: begin
					if (cr_cnt_q == 8'h0) begin
						cr_q     <= CR_REL;
						clkrun_o <= 1'b1;
					end else begin
						cr_cnt_q <= cr_cnt_q - 8'h1;
					end
				end
				CR_REL: begin
					cr_q      <= CR_IDLE;
					clkrun_oe <= 1'b0;
				end
				default: begin
					cr_q      <= CR_IDLE;
					clkrun_oe <= 1'b0;
				end
			endcase
		end
	end

	// Card clock: asserted clock-run while running, released to ask for a stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cc_q        <= CC_RUN;
			idle_cnt_q  <= 8'h0;
			cclkrun_o   <= 1'b0;
			cclkrun_oe  <= 1'b1;
			card_clk_en <= 1'b1;
		end else begin
			case (cc_q)
				CC_RUN: begin
					idle_cnt_q <= card_idle ? idle_cnt_q + 8'h1 : 8'h0;
					if (card_idle && idle_cnt_q == 8'(IDLE_CYC - 1)) begin
						cc_q       <= CC_REQ;
						idle_cnt_q <= 8'h0;
						cclkrun_oe <= 1'b0;
					end
				end
				CC_REQ: begin
					idle_cnt_q <= idle_cnt_q + 8'h1;
					if (!cclkrun_i || !card_idle) begin
						cc_q       <= CC_RUN;
						idle_cnt_q <= 8'h0;
						cclkrun_oe <= 1'b1;
					end else if (idle_cnt_q == 8'(CRUN_CYC - 1)) begin
						cc_q        <= CC_STOP;
						card_clk_en <= 1'b0;
					end
				end
				CC_STOP: begin
					if (cc_wake || !card_idle) begin
						cc_q        <= CC_RUN;
						idle_cnt_q  <= 8'h0;
						cclkrun_oe  <= 1'b1;
						card_clk_en <= 1'b1;
					end
				end
				default: begin
					cc_q        <= CC_RUN;
					cclkrun_oe  <= 1'b1;
					card_clk_en <= 1'b1;
				end
			endcase
		end
	end

	// Suspend takes effect only once the device holds no grant
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			susp_q             <= 1'b0;
			pci_out_hiz        <= 1'b0;
			pci_clk_gate       <= 1'b0;
			pci_reset_out_n    <= 1'b0;
			global_reset_out_n <= 1'b0;
			wake_o             <= 1'b0;
			wake_oe            <= 1'b0;
			ring_wake_output   <= 1'b0;
			card_hiz           <= 1'b0;
			card_reset         <= 1'b0;
			csc_serial_send    <= 1'b0;
		end else begin
			if (!suspend_in)
				susp_q <= 1'b0;
			else if (!gnt_active)
				susp_q <= 1'b1;
			pci_out_hiz        <= susp_q;
			pci_clk_gate       <= susp_q;
			pci_reset_out_n    <= susp_q | pci_reset_input_n;
			global_reset_out_n <= susp_q | global_reset_input_n;
			wake_o             <= 1'b0;
			wake_oe            <= wake_st_q & wake_en_q;
			ring_wake_output   <= ring_in & ctrl_q[B_RING_EN];
			card_hiz           <= ctrl_q[B_COE] | (ctrl_q[B_APD] & card_idle);
			card_reset         <= ctrl_q[B_COE];
			// The serial stream has no clock of its own
			csc_serial_send    <= csc_serial_req & ~susp_q;
		end
	end

	property p_unmasked_wake;
		@(posedge aclk) disable iff (reg_rst)
		(pstate_q == PS_D0 && irq_pend) |=> wake_st_q;
	endproperty
	AST_WAKE_D0: assert property (p_unmasked_wake) else $error("unmasked event lost");
	AST_SKIP_GIE: assert property (@(posedge aclk) disable iff (reg_rst)
		(ctrl_q[B_SKIP] && (|(flags_q & mask_q))) |-> irq_pend)
		else $error("skip did not bypass enable");
	AST_GIE_NEEDED: assert property (@(posedge aclk) disable iff (reg_rst)
		(!ctrl_q[B_SKIP] && !ctrl_q[B_GIE]) |-> !irq_pend)
		else $error("event qualified without enable");
	AST_OPEN_DRAIN: assert property (@(posedge aclk) disable iff (!aresetn)
		!wake_o) else $error("wake output driven high");
	// Enable must survive one more cycle, software may drop it meanwhile
	sequence s_insert_enabled;
		(card_insert && wake_en_q) ##1 wake_en_q;
	endsequence
	AST_INSERT_WAKE: assert property (@(posedge aclk) disable iff (reg_rst)
		s_insert_enabled |=> wake_oe)
		else $error("insertion did not wake");
	AST_HOLD_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
		(cr_q == CR_IDLE && clkrun_i && hold_any) |=> clkrun_oe && !clkrun_o)
		else $error("stop not refused");
	sequence s_card_idle_long;
		(cc_q == CC_RUN && card_idle) [*8];
	endsequence
	AST_CARD_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
		(cc_q == CC_STOP) |-> !card_clk_en)
		else $error("card clock running while stopped");
	AST_COE_RESET: assert property (@(posedge aclk) disable iff (reg_rst)
		ctrl_q[B_COE] |=> card_hiz && card_reset)
		else $error("output disable without reset");
	AST_APD_NORESET: assert property (@(posedge aclk) disable iff (reg_rst)
		(ctrl_q[B_APD] && !ctrl_q[B_COE] && card_idle) |=> card_hiz && !card_reset)
		else $error("auto power down wrong");
	AST_SUSP_DEFER: assert property (@(posedge aclk) disable iff (!aresetn)
		(suspend_in && gnt_active && !susp_q) |=> !susp_q)
		else $error("suspend not deferred");
	AST_SUSP_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		(susp_q && !pci_reset_input_n && !wr_go) |=> $stable(ctrl_q))
		else $error("registers cleared in suspend");
	AST_SUSP_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		susp_q |=> pci_clk_gate && pci_out_hiz && pci_reset_out_n)
		else $error("suspend gating missing");
	AST_ID_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_ident[ID_SKIP] == ctrl_q[B_SKIP]) else $error("ident bit wrong");
	AST_IDLE_REQ: assert property (@(posedge aclk) disable iff (!aresetn)
		s_card_idle_long |-> ##[0:40] ((cc_q != CC_RUN) || !card_idle))
		else $error("idle card clock not stopped");
endmodule

// >>> test/pci_clk_host.sv
// Behavioural central clock resource driving the PCI clock-run line
`timescale 1ns/10ps
module pci_clk_host (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic stop_req,
	input  wire logic clkrun_line,
	output logic      host_oe,
	output logic      stopped
);
	logic [2:0] hi_cnt_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_oe  <= 1'b1;
			stopped  <= 1'b0;
			hi_cnt_q <= 3'h0;
		end else if (host_oe) begin
			host_oe  <= !stop_req;
			hi_cnt_q <= 3'h0;
		end else if (!clkrun_line) begin
			// Device pulled the line low: clock must run again
			host_oe <= 1'b1;
			stopped <= 1'b0;
		end else if (hi_cnt_q == 3'h4) begin
			stopped <= 1'b1;
		end else begin
			hi_cnt_q <= hi_cnt_q + 3'h1;
		end
	end
endmodule

// >>> test/test_bridge_power_management.sv
// Self-checking bench for the bridge power-management block
`timescale 1ns/10ps
module test_bridge_power_management;
	localparam logic [31:0] PM_CLR_EN = (32'h1 << bridge_pm_pkg::PM_WAKE_ST) |
		(32'h1 << bridge_pm_pkg::PM_WAKE_EN);
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] event_in, ev, mk;
	logic        sk, ge, stop_req, card_pull, host_oe, stopped;
	bridge_pm_pkg::busy_t     busy;
	bridge_pm_pkg::wake_src_t wake_src;
	logic card_insert, card_idle, ring_in, suspend_in, pci_reset_input_n, global_reset_input_n;
	logic gnt_active, clkrun_i, clkrun_o, clkrun_oe, cclkrun_i, cclkrun_o, cclkrun_oe, wake_o;
	logic wake_oe, ring_wake_output, card_clk_en, card_hiz, card_reset, pci_out_hiz;
	logic pci_clk_gate, pci_reset_out_n, global_reset_out_n, csc_serial_req, csc_serial_send;
	int   error_cnt = 0;
	int   compares = 0;
	int   cyc = 0;

	bridge_power_management i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.event_in, .card_insert, .busy, .wake_src, .card_idle, .ring_in, .suspend_in,
		.pci_reset_input_n, .global_reset_input_n, .gnt_active, .clkrun_i, .clkrun_o,
		.clkrun_oe, .cclkrun_i, .cclkrun_o, .cclkrun_oe, .wake_o, .wake_oe, .ring_wake_output,
		.card_clk_en, .card_hiz, .card_reset, .pci_out_hiz, .pci_clk_gate, .pci_reset_out_n,
		.global_reset_out_n, .csc_serial_req, .csc_serial_send);
	pci_clk_host i_host (.aclk, .aresetn, .stop_req, .clkrun_line(clkrun_i), .host_oe,
		.stopped);

	// Wired-low line with pull-up; a high drive loses against a low one
	assign clkrun_i  = !(host_oe || (clkrun_oe && !clkrun_o));
	assign cclkrun_i = cclkrun_oe ? cclkrun_o : !card_pull;

	always #12.5 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (error_cnt == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	function automatic logic wake_exp(input logic [15:0] e, input logic [15:0] m,
		input logic s, input logic g);
		return (|(e & m)) && (s || g);
	endfunction

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		{event_in, busy, wake_src} = 28'h0;
		{card_insert, ring_in, suspend_in, gnt_active, csc_serial_req, stop_req, card_pull} = 7'h0;
		{card_idle, pci_reset_input_n, global_reset_input_n} = 3'h7;
		void'($urandom(32'h20b0));
		tick(20);
		aresetn <= 1'b1;
		rd(bridge_pm_pkg::OFF_CTRL);
		chk(d, {25'h0, bridge_pm_pkg::CTRL_RST});
		rd(bridge_pm_pkg::OFF_IDENT);
		chk(d[bridge_pm_pkg::ID_SKIP], 1'b0);
		rd(8'h40);
		chk(r, bridge_pm_pkg::RESP_SLV);
		wr(8'h44, 32'h1);
		chk(r, bridge_pm_pkg::RESP_SLV);
		wr(bridge_pm_pkg::OFF_CTRL, 32'h1 << bridge_pm_pkg::B_SKIP);
		rd(bridge_pm_pkg::OFF_IDENT);
		chk(d, bridge_pm_pkg::IDENT_BASE | (32'h1 << bridge_pm_pkg::ID_SKIP));
		for (int i = 0; i < 4; i++) begin
			wr(bridge_pm_pkg::OFF_PMCSR, i);
			rd(bridge_pm_pkg::OFF_PMCSR);
			chk(d[1:0], i[1:0]);
		end
		for (int i = 0; i < 10; i++) begin
			ev = 16'($urandom);
			mk = 16'($urandom);
			{sk, ge} = 2'($urandom);
			// Disjoint event and mask bits must not combine
			if (i == 0) {ev, mk, sk, ge} = {16'h0001, 16'h0002, 2'h3};
			if (i == 1) {ev, mk, sk, ge} = {16'h8000, 16'h8000, 2'h0};
			wr(bridge_pm_pkg::OFF_FLAGS, 32'hffff);
			wr(bridge_pm_pkg::OFF_CTRL, (32'(sk) << bridge_pm_pkg::B_SKIP) |
				(32'(ge) << bridge_pm_pkg::B_GIE));
			wr(bridge_pm_pkg::OFF_MASK, {16'h0, mk});
			wr(bridge_pm_pkg::OFF_PMCSR, PM_CLR_EN);
			event_in <= ev;
			@(posedge aclk) event_in <= 16'h0;
			tick(3);
			chk(wake_oe, wake_exp(ev, mk, sk, ge));
			chk(wake_o, 1'b0);
			rd(bridge_pm_pkg::OFF_FLAGS);
			chk(d, {16'h0, ev});
			rd(bridge_pm_pkg::OFF_PMCSR);
			chk(d[bridge_pm_pkg::PM_WAKE_ST], wake_exp(ev, mk, sk, ge));
		end
		wr(bridge_pm_pkg::OFF_FLAGS, 32'hffff);
		wr(bridge_pm_pkg::OFF_MASK, 32'h0);
		wr(bridge_pm_pkg::OFF_CTRL, 32'h0);
		wr(bridge_pm_pkg::OFF_PMCSR, PM_CLR_EN);
		card_insert <= 1'b1;
		@(posedge aclk) card_insert <= 1'b0;
		tick(3);
		chk(wake_oe, 1'b1);
		wr(bridge_pm_pkg::OFF_PMCSR, 32'h1 << bridge_pm_pkg::PM_WAKE_ST);
		tick(3);
		chk(wake_oe, 1'b0);
		chk(card_clk_en, 1'b0);
		for (int i = 0; i < 12; i++) begin
			if (i < 8) busy <= 8'h1 << i;
			else if (i < 10) wr(bridge_pm_pkg::OFF_CTRL, 32'h1 << (i - 8));
			else if (i == 10) card_idle <= 1'b0;
			else begin
				// Pending needs an enabled, unmasked flag
				wr(bridge_pm_pkg::OFF_MASK, 32'h1);
				wr(bridge_pm_pkg::OFF_CTRL, 32'h1 << bridge_pm_pkg::B_GIE);
				event_in <= 16'h1;
			end
			stop_req <= 1'b1;
			tick(20);
			chk(stopped, 1'b0);
			if (i == 10) chk(card_clk_en, 1'b1);
			stop_req <= 1'b0;
			{busy, card_idle, event_in} <= {8'h0, 1'b1, 16'h0};
			wr(bridge_pm_pkg::OFF_CTRL, 32'h0);
			wr(bridge_pm_pkg::OFF_FLAGS, 32'hffff);
			wr(bridge_pm_pkg::OFF_MASK, 32'h0);
			tick(50);
		end
		for (int j = 0; j < 7; j++) begin
			stop_req <= 1'b1;
			tick(20);
			chk(stopped, 1'b1);
			stop_req <= 1'b0;
			if (j < 4) wake_src <= 4'h1 << j;
			else if (j == 4) card_pull <= 1'b1;
			else if (j == 5) ring_in <= 1'b1;
			else busy <= 8'h01;
			tick(10);
			chk(stopped, 1'b0);
			{wake_src, card_pull, busy, ring_in} <= 14'h0;
			tick(60);
		end
		wr(bridge_pm_pkg::OFF_CTRL, 32'h1 << bridge_pm_pkg::B_COE);
		tick(3);
		chk({card_hiz, card_reset}, 2'b11);
		wr(bridge_pm_pkg::OFF_CTRL, 32'h1 << bridge_pm_pkg::B_APD);
		tick(3);
		chk({card_hiz, card_reset}, 2'b10);
		card_idle <= 1'b0;
		tick(3);
		chk(card_hiz, 1'b0);
		card_idle <= 1'b1;
		wr(bridge_pm_pkg::OFF_CTRL, 32'h1 << bridge_pm_pkg::B_RING_EN);
		{gnt_active, suspend_in} <= 2'h3;
		tick(4);
		chk({pci_out_hiz, pci_clk_gate}, 2'b00);
		gnt_active <= 1'b0;
		tick(4);
		chk({pci_out_hiz, pci_clk_gate}, 2'b11);
		{pci_reset_input_n, global_reset_input_n, ring_in, csc_serial_req} <= 4'h3;
		tick(4);
		chk({pci_reset_out_n, global_reset_out_n, ring_wake_output, csc_serial_send},
			4'he);
		{pci_reset_input_n, global_reset_input_n, suspend_in} <= 3'h6;
		tick(4);
		chk(csc_serial_send, 1'b1);
		rd(bridge_pm_pkg::OFF_CTRL);
		chk(d, 32'h1 << bridge_pm_pkg::B_RING_EN);
		pci_reset_input_n <= 1'b0;
		tick(3);
		chk(pci_reset_out_n, 1'b0);
		pci_reset_input_n <= 1'b1;
		rd(bridge_pm_pkg::OFF_CTRL);
		chk(d, 32'h0);
		print_verdict();
	end
endmodule
